// ### hdl/mpf_map.vh
// constants for the multipurpose pin function select block
// assumes a 200 MHz pclk and an APB bus with 32-bit data
`ifndef MPF_MAP_VH
`define MPF_MAP_VH

// --------------------------------------------------------------
// register indices (byte address is four times the index)
// --------------------------------------------------------------
`define MPF_IDX_MIC_PIN_SEL 8'h3d
`define MPF_IDX_SER_PIN_SEL 8'h3e
`define MPF_IDX_VOL_SETUP 8'h3f
`define MPF_IDX_VOL_CONV 8'h40
`define MPF_IDX_STATUS 8'h42

// --------------------------------------------------------------
// reset values
// --------------------------------------------------------------
`define MPF_RST_MIC_PIN_SEL 8'h00
`define MPF_RST_SER_PIN_SEL 8'h11
`define MPF_RST_VOL_SETUP 8'h00
`define MPF_RST_VOL_CONV 8'h87

// --------------------------------------------------------------
// field positions
// --------------------------------------------------------------
`define MPF_FLD_CODE 4:0
`define MPF_FLD_START 7:3
`define MPF_FLD_HOLD 2:0
`define MPF_FLD_INCR 7:6
`define MPF_FLD_CONV 2:0
`define MPF_CONV_NONE 3'h7

// --------------------------------------------------------------
// pin function codes
// --------------------------------------------------------------
`define MPF_FN_PRIMARY 5'h00
`define MPF_FN_MUTE_ADC0 5'h01
`define MPF_FN_MUTE_ADC1 5'h02
`define MPF_FN_MUTE_ADC2 5'h03
`define MPF_FN_MUTE_ADC3 5'h04
`define MPF_FN_MUTE_ADC01 5'h05
`define MPF_FN_MUTE_ADC23 5'h06
`define MPF_FN_MUTE_ADCS 5'h07
`define MPF_FN_MUTE_DAC0 5'h08
`define MPF_FN_MUTE_DAC1 5'h09
`define MPF_FN_MUTE_DACS 5'h0a
`define MPF_FN_BANK 5'h0b
`define MPF_FN_COMP 5'h0e
`define MPF_FN_BYPASS 5'h0f
`define MPF_FN_VOL_UP 5'h10
`define MPF_FN_VOL_DOWN 5'h11
`define MPF_FN_CLOCK_OUTPUT_FUNCTION 5'h12

// --------------------------------------------------------------
// timing and volume (levels in 0.375 dB units)
// --------------------------------------------------------------
`define MPF_CLK_KHZ 200000
`define MPF_TICK_MS 1
`define MPF_RAMP_MS 11'h032
`define MPF_HOLD0_MS 11'h096
`define MPF_HOLD1_MS 11'h12c
`define MPF_HOLD2_MS 11'h1c2
`define MPF_HOLD3_MS 11'h258
`define MPF_HOLD4_MS 11'h384
`define MPF_HOLD5_MS 11'h4b0
`define MPF_START_UNITS 4
`define MPF_LEVEL_FLOOR 9'h100

`endif

// ### hdl/mpf_pin_func.v
// decodes one multipurpose pin's function code into control levels
// assumes the pin level is already synchronised to pclk (high = pressed)
`include "mpf_map.vh"

module mpf_pin_func (
	input wire [4:0] code,
	input wire pressed,
	output reg [3:0] adc_mute,
	output reg [1:0] dac_mute,
	output reg bank_req,
	output reg comp_req,
	output reg bypass_req,
	output reg vol_up_req,
	output reg vol_down_req
);

	// --------------------------------------------------------------
	// function decode
	// --------------------------------------------------------------

	// controls are levels that follow the button while it is held
	always @*
	begin
		adc_mute = 4'h0;
		dac_mute = 2'h0;
		bank_req = 1'b0;
		comp_req = 1'b0;
		bypass_req = 1'b0;
		vol_up_req = 1'b0;
		vol_down_req = 1'b0;
		case (code)
			`MPF_FN_MUTE_ADC0: adc_mute = {3'h0, pressed};
			`MPF_FN_MUTE_ADC1: adc_mute = {2'h0, pressed, 1'b0};
			`MPF_FN_MUTE_ADC2: adc_mute = {1'b0, pressed, 2'h0};
			`MPF_FN_MUTE_ADC3: adc_mute = {pressed, 3'h0};
			`MPF_FN_MUTE_ADC01: adc_mute = {2'h0, {2{pressed}}};
			`MPF_FN_MUTE_ADC23: adc_mute = {{2{pressed}}, 2'h0};
			`MPF_FN_MUTE_ADCS: adc_mute = {4{pressed}};
			`MPF_FN_MUTE_DAC0: dac_mute = {1'b0, pressed};
			`MPF_FN_MUTE_DAC1: dac_mute = {pressed, 1'b0};
			`MPF_FN_MUTE_DACS: dac_mute = {2{pressed}};
			`MPF_FN_BANK: bank_req = pressed;
			`MPF_FN_COMP: comp_req = pressed;
			`MPF_FN_BYPASS: bypass_req = pressed;
			`MPF_FN_VOL_UP: vol_up_req = pressed;
			`MPF_FN_VOL_DOWN: vol_down_req = pressed;
			// reserved and out-of-range codes do nothing
			default: adc_mute = 4'h0;
		endcase
	end

endmodule

// ### hdl/mpf_top.v
// multipurpose pin function select and push-button volume setup
// assumes an APB master on pclk; pin inputs are asynchronous
`include "mpf_map.vh"

module mpf_top #(
	parameter MS_TICK_CYCLES = `MPF_CLK_KHZ * `MPF_TICK_MS
) (
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire second_microphone_pin_in,
	input wire serial_out_or_clock_pin_in,
	output reg serial_out_or_clock_pin_out,
	output reg serial_out_or_clock_pin_oe,
	input wire serial_data_src,
	input wire clock_output_function_src,
	output reg mic_data_out,
	output reg mic_data_valid,
	output reg [3:0] adc_mute,
	output reg [1:0] dac_mute,
	output reg bank_select,
	output reg compression_enable,
	output reg bypass_enable,
	output reg button_volume_active,
	output reg [8:0] button_volume_level,
	output wire [2:0] button_volume_converter_select,
	output wire [1:0] button_gain_increment
);

	// --------------------------------------------------------------
	// register file
	// --------------------------------------------------------------

	reg [7:0] mic_sel_q;
	reg [7:0] ser_sel_q;
	reg [7:0] vol_setup_q;
	reg [7:0] vol_conv_q;
	reg setup_written_q;

	wire [9:0] word_idx;
	wire setup_ph;
	wire access_ph;
	wire hit_mic;
	wire hit_ser;
	wire hit_setup;
	wire hit_conv;
	wire hit_stat;
	wire mapped;
	wire [31:0] status_word;

	assign word_idx = paddr[11:2];
	assign setup_ph = psel & ~penable;
	assign access_ph = psel & penable;
	assign hit_mic = (word_idx == {2'h0, `MPF_IDX_MIC_PIN_SEL});
	assign hit_ser = (word_idx == {2'h0, `MPF_IDX_SER_PIN_SEL});
	assign hit_setup = (word_idx == {2'h0, `MPF_IDX_VOL_SETUP});
	assign hit_conv = (word_idx == {2'h0, `MPF_IDX_VOL_CONV});
	assign hit_stat = (word_idx == {2'h0, `MPF_IDX_STATUS});
	assign mapped = hit_mic | hit_ser | hit_setup | hit_conv | hit_stat;

	// zero wait states; read data is staged in the setup cycle
	assign pready = 1'b1;
	// unmapped addresses and writes to status answer with an error
	assign pslverr = access_ph & (~mapped | (hit_stat & pwrite));

	assign status_word = {20'h0000_0, setup_written_q, bank_select,
		button_volume_active, button_volume_level};

	// register writes take effect in the access phase
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mic_sel_q <= `MPF_RST_MIC_PIN_SEL;
			ser_sel_q <= `MPF_RST_SER_PIN_SEL;
			vol_setup_q <= `MPF_RST_VOL_SETUP;
			vol_conv_q <= `MPF_RST_VOL_CONV;
			setup_written_q <= 1'b0;
		end
		else if (access_ph && pwrite)
		begin
			// reserved high bits keep what was written
			if (hit_mic)
				mic_sel_q <= pwdata[7:0];
			if (hit_ser)
				ser_sel_q <= pwdata[7:0];
			if (hit_setup)
				vol_setup_q <= pwdata[7:0];
			// remember that software set up the volume
			if (hit_setup)
				setup_written_q <= 1'b1;
			if (hit_conv)
				vol_conv_q <= pwdata[7:0];
		end
	end

	// read data latched so prdata comes from a flip-flop
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0000_0000;
		else if (setup_ph && !pwrite)
		begin
			if (hit_mic)
				prdata <= {24'h00_0000, mic_sel_q};
			else if (hit_ser)
				prdata <= {24'h00_0000, ser_sel_q};
			else if (hit_setup)
				prdata <= {24'h00_0000, vol_setup_q};
			else if (hit_conv)
				prdata <= {24'h00_0000, vol_conv_q};
			else if (hit_stat)
				prdata <= status_word;
			else
				prdata <= 32'h0000_0000;
		end
	end

	assign button_volume_converter_select = vol_conv_q[`MPF_FLD_CONV];
	assign button_gain_increment = vol_conv_q[`MPF_FLD_INCR];

	// --------------------------------------------------------------
	// pin synchronisers and function decode
	// --------------------------------------------------------------

	wire [1:0] pin_raw;
	wire [9:0] pin_code;
	wire [1:0] pin_lvl;
	wire [7:0] fn_adc;
	wire [3:0] fn_dac;
	wire [1:0] fn_bank;
	wire [1:0] fn_comp;
	wire [1:0] fn_bypass;
	wire [1:0] fn_up;
	wire [1:0] fn_down;

	assign pin_raw = {serial_out_or_clock_pin_in, second_microphone_pin_in};
	assign pin_code[4:0] = mic_sel_q[`MPF_FLD_CODE];
	assign pin_code[9:5] = ser_sel_q[`MPF_FLD_CODE];

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1)
		begin : g_pin
			reg [1:0] sync_q;
			// two flops before any logic sees the pin
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
					sync_q <= 2'b00;
				else
					sync_q <= {sync_q[0], pin_raw[gi]};
			end
			assign pin_lvl[gi] = sync_q[1];

			mpf_pin_func u_func (
				.code(pin_code[gi*5+4:gi*5]),
				.pressed(sync_q[1]),
				.adc_mute(fn_adc[gi*4+3:gi*4]),
				.dac_mute(fn_dac[gi*2+1:gi*2]),
				.bank_req(fn_bank[gi]),
				.comp_req(fn_comp[gi]),
				.bypass_req(fn_bypass[gi]),
				.vol_up_req(fn_up[gi]),
				.vol_down_req(fn_down[gi])
			);
		end
	endgenerate

	// --------------------------------------------------------------
	// pin routing and control outputs
	// --------------------------------------------------------------

	wire bank_any;
	wire up_any;
	wire down_any;
	reg bank_prev_q;

	assign bank_any = |fn_bank;
	assign up_any = |fn_up;
	assign down_any = |fn_down;

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mic_data_out <= 1'b0;
			mic_data_valid <= 1'b0;
			serial_out_or_clock_pin_out <= 1'b0;
			serial_out_or_clock_pin_oe <= 1'b0;
			adc_mute <= 4'h0;
			dac_mute <= 2'h0;
			compression_enable <= 1'b0;
			bypass_enable <= 1'b0;
			bank_select <= 1'b0;
			bank_prev_q <= 1'b0;
		end
		else
		begin
			// code zero passes microphone data inward
			mic_data_valid <= (pin_code[4:0] == `MPF_FN_PRIMARY);
			mic_data_out <= (pin_code[4:0] == `MPF_FN_PRIMARY) & pin_lvl[0];
			// pin driven only for serial data or clock out
			serial_out_or_clock_pin_oe <=
				(pin_code[9:5] == `MPF_FN_PRIMARY) |
				(pin_code[9:5] == `MPF_FN_CLOCK_OUTPUT_FUNCTION);
			if (pin_code[9:5] == `MPF_FN_CLOCK_OUTPUT_FUNCTION)
				serial_out_or_clock_pin_out <= clock_output_function_src;
			else if (pin_code[9:5] == `MPF_FN_PRIMARY)
				serial_out_or_clock_pin_out <= serial_data_src;
			else
				serial_out_or_clock_pin_out <= 1'b0;
			adc_mute <= fn_adc[3:0] | fn_adc[7:4];
			dac_mute <= fn_dac[1:0] | fn_dac[3:2];
			// held levels; bank flips once per press
			compression_enable <= |fn_comp;
			bypass_enable <= |fn_bypass;
			bank_prev_q <= bank_any;
			if (bank_any && !bank_prev_q)
				bank_select <= ~bank_select;
		end
	end

	// --------------------------------------------------------------
	// millisecond tick
	// --------------------------------------------------------------

	reg [17:0] tick_cnt_q;
	wire ms_tick;

	assign ms_tick = (tick_cnt_q == MS_TICK_CYCLES[17:0] - 18'h0_0001);

	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tick_cnt_q <= 18'h0_0000;
		else if (ms_tick)
			tick_cnt_q <= 18'h0_0000;
		else
			tick_cnt_q <= tick_cnt_q + 18'h0_0001;
	end

	// --------------------------------------------------------------
	// push-button volume
	// --------------------------------------------------------------

	reg [10:0] hold_lim;
	reg [8:0] step_units;
	reg [10:0] ms_cnt_q;
	reg ramp_q;
	reg up_prev_q;
	reg down_prev_q;
	reg conv_on_prev_q;
	wire conv_on;
	wire held;
	wire press;
	wire hold_valid;
	wire ms_next_hit;
	wire do_step;
	wire [8:0] start_units;
	wire [9:0] lvl_down_sum;

	// active only when converter select is not 111
	assign conv_on = (vol_conv_q[`MPF_FLD_CONV] != `MPF_CONV_NONE);
	assign held = up_any ^ down_any;
	assign press = (up_any & ~up_prev_q) | (down_any & ~down_prev_q);
	// hold codes 110 and 111 never start a ramp
	assign hold_valid = (vol_setup_q[2:1] != 2'b11);
	assign ms_next_hit = ramp_q ? (ms_cnt_q + 11'h001 == `MPF_RAMP_MS) :
		(hold_valid & (ms_cnt_q + 11'h001 == hold_lim));
	assign do_step = held & (press | (ms_tick & ms_next_hit));
	// 1.5 dB per count is four 0.375 dB units
	assign start_units = {2'b00, vol_setup_q[`MPF_FLD_START], 2'b00};
	assign lvl_down_sum = {1'b0, button_volume_level} + {1'b0, step_units};

	always @*
	begin
		case (vol_setup_q[`MPF_FLD_HOLD])
			3'h0: hold_lim = `MPF_HOLD0_MS;
			3'h1: hold_lim = `MPF_HOLD1_MS;
			3'h2: hold_lim = `MPF_HOLD2_MS;
			3'h3: hold_lim = `MPF_HOLD3_MS;
			3'h4: hold_lim = `MPF_HOLD4_MS;
			3'h5: hold_lim = `MPF_HOLD5_MS;
			default: hold_lim = 11'h000;
		endcase
	end

	// per-press step in 0.375 dB units
	always @*
	begin
		case (vol_conv_q[`MPF_FLD_INCR])
			2'h0: step_units = 9'h001;
			2'h1: step_units = 9'h004;
			2'h2: step_units = 9'h008;
			default: step_units = 9'h00c;
		endcase
	end

	// hold timer; a release or both buttons at once cancels a ramp
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ms_cnt_q <= 11'h000;
			ramp_q <= 1'b0;
			up_prev_q <= 1'b0;
			down_prev_q <= 1'b0;
		end
		else
		begin
			up_prev_q <= up_any;
			down_prev_q <= down_any;
			if (!held || press)
			begin
				ms_cnt_q <= 11'h000;
				ramp_q <= 1'b0;
			end
			else if (ms_tick)
			begin
				// ramp begins once the hold time elapses
				if (ms_next_hit)
				begin
					ms_cnt_q <= 11'h000;
					ramp_q <= 1'b1;
				end
				else if (ms_cnt_q != 11'h7ff)
					ms_cnt_q <= ms_cnt_q + 11'h001;
			end
		end
	end

	// level is attenuation; enabling reloads the start point
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			button_volume_level <= 9'h000;
			button_volume_active <= 1'b0;
			conv_on_prev_q <= 1'b0;
		end
		else
		begin
			conv_on_prev_q <= conv_on;
			button_volume_active <= conv_on;
			// unset setup loads the -96 dB floor
			if (conv_on && !conv_on_prev_q)
			begin
				if (setup_written_q)
					button_volume_level <= start_units;
				else
					button_volume_level <= `MPF_LEVEL_FLOOR;
			end
			else if (conv_on && do_step)
			begin
				// up lowers attenuation, down raises it
				if (up_any)
				begin
					if (button_volume_level > step_units)
						button_volume_level <= button_volume_level - step_units;
					else
						button_volume_level <= 9'h000;
				end
				else if (lvl_down_sum > {1'b0, `MPF_LEVEL_FLOOR})
					button_volume_level <= `MPF_LEVEL_FLOOR;
				else
					button_volume_level <= lvl_down_sum[8:0];
			end
		end
	end

endmodule

// ### dv/mpf_top_monitor.sv
// checker for the pin function select block, bound into mpf_top
// assumes writes land at the apb access edge and pins are active high
module mpf_top_monitor (
	input wire pclk,
	input wire presetn,
	input wire [11:0] paddr,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] pwdata,
	input wire pready,
	input wire pslverr,
	input wire second_microphone_pin_in,
	input wire serial_out_or_clock_pin_in,
	input wire serial_out_or_clock_pin_out,
	input wire serial_out_or_clock_pin_oe,
	input wire serial_data_src,
	input wire clock_output_function_src,
	input wire mic_data_out,
	input wire mic_data_valid,
	input wire [3:0] adc_mute,
	input wire [1:0] dac_mute,
	input wire bank_select,
	input wire compression_enable,
	input wire bypass_enable,
	input wire button_volume_active,
	input wire [8:0] button_volume_level,
	input wire [2:0] button_volume_converter_select
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [4:0] mic_q;
	logic [4:0] ser_q;
	logic [1:0] up_q;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// selector mirror
	// ----------------------------------------
	// age counter skips the output flops still filling after reset
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mic_q <= 5'h00;
			ser_q <= 5'h11;
			up_q <= 2'h0;
		end
		else
		begin
			if (up_q != 2'h3)
				up_q <= up_q + 2'h1;
			if (psel && penable && pwrite && pready && paddr == 12'h0f4)
				mic_q <= pwdata[4:0];
			if (psel && penable && pwrite && pready && paddr == 12'h0f8)
				ser_q <= pwdata[4:0];
		end
	end
	// ----------------------------------------
	// assertions
	// ----------------------------------------
	map_error_a:
		assert property (psel && penable |-> pslverr == (!(paddr inside
			{12'h0f4, 12'h0f8, 12'h0fc, 12'h100, 12'h108}) ||
			(pwrite && paddr == 12'h108)))
		else $error("slave error does not match the address map");
	mic_route_a:
		assert property (up_q != 2'h0 |->
			mic_data_valid == ($past(mic_q) == 5'h00))
		else $error("mic data path enable wrong for selector");
	mic_data_a:
		assert property (up_q == 2'h3 && mic_data_valid |->
			mic_data_out == $past(second_microphone_pin_in, 3))
		else $error("mic data not the pin three edges back");
	ser_drive_a:
		assert property (up_q != 2'h0 |-> serial_out_or_clock_pin_oe ==
			($past(ser_q) == 5'h00 || $past(ser_q) == 5'h12))
		else $error("serial pin drive enable wrong for selector");
	ser_source_a:
		assert property (serial_out_or_clock_pin_oe |->
			serial_out_or_clock_pin_out == ($past(ser_q) == 5'h00 ?
			$past(serial_data_src) : $past(clock_output_function_src)))
		else $error("serial pin carries the wrong source");
	button_gate_a:
		assert property (button_volume_active ==
			($past(button_volume_converter_select) != 3'h7))
		else $error("button volume active does not follow select");
	idle_quiet_a:
		assert property ((!second_microphone_pin_in &&
			!serial_out_or_clock_pin_in)[*4] |-> adc_mute == 4'h0 &&
			dac_mute == 2'h0 && !compression_enable && !bypass_enable)
		else $error("control asserted with no button pressed");
	level_range_a:
		assert property (button_volume_level <= 9'h100)
		else $error("button volume below the floor");
	bank_cause_a:
		assert property ($changed(bank_select) |->
			$past(second_microphone_pin_in, 3) ||
			$past(serial_out_or_clock_pin_in, 3))
		else $error("bank toggled without a press");
	bank_seen_c: cover property ($rose(bank_select));
	floor_seen_c: cover property (button_volume_active &&
		button_volume_level == 9'h100);
	drive_seen_c: cover property (serial_out_or_clock_pin_oe &&
		serial_out_or_clock_pin_out);
endmodule
bind mpf_top mpf_top_monitor mpf_top_monitor_inst (.pclk(pclk),
	.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
	.second_microphone_pin_in(second_microphone_pin_in),
	.serial_out_or_clock_pin_in(serial_out_or_clock_pin_in),
	.serial_out_or_clock_pin_out(serial_out_or_clock_pin_out),
	.serial_out_or_clock_pin_oe(serial_out_or_clock_pin_oe),
	.serial_data_src(serial_data_src),
	.clock_output_function_src(clock_output_function_src),
	.mic_data_out(mic_data_out), .mic_data_valid(mic_data_valid),
	.adc_mute(adc_mute), .dac_mute(dac_mute), .bank_select(bank_select),
	.compression_enable(compression_enable),
	.bypass_enable(bypass_enable),
	.button_volume_active(button_volume_active),
	.button_volume_level(button_volume_level),
	.button_volume_converter_select(button_volume_converter_select));

// ### dv/mpf_button_model.sv
// push-button model for the two multipurpose pins
// assumes a pull-down on each pin, so a released button reads low
module mpf_button_model (
	input wire pclk,
	output logic mic_pin,
	output logic ser_pin
);
	timeunit 1ns;
	timeprecision 100ps;
	// both buttons released at power-up
	initial
	begin
		mic_pin = 1'b0;
		ser_pin = 1'b0;
	end
	// press or release one button just after an edge
	task automatic set_pin(input int p, input logic v);
		@(posedge pclk);
		if (p == 0)
			mic_pin <= v;
		else
			ser_pin <= v;
	endtask
endmodule

// ### dv/mpf_top_tb.sv
// self-checking bench: registers over apb, buttons through the model
// assumes the ms tick is shortened to ten pclk cycles
module mpf_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic sdat = 0, cksrc = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, rd;
	wire [31:0] prdata;
	wire pready, pslverr, mic_pin, ser_pin, pin_out, pin_oe, mic_out;
	wire mic_vld, bank, comp, byp, vol_act;
	wire [3:0] adc_mute;
	wire [1:0] dac_mute, gain;
	wire [8:0] level;
	wire [2:0] conv;
	int mismatches = 0, n_tests = 0, lvl;
	logic [4:0] mcode [14] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06,
		5'h07, 5'h08, 5'h09, 5'h0a, 5'h0c, 5'h0d, 5'h0e, 5'h0f};
	logic [7:0] mexp [14] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h03, 8'h0c,
		8'h0f, 8'h10, 8'h20, 8'h30, 8'h00, 8'h00, 8'h40, 8'h80};
	logic [11:0] radr [4] = '{12'h0f4, 12'h0f8, 12'h0fc, 12'h100};
	logic [7:0] rexp [4] = '{8'h00, 8'h11, 8'h00, 8'h87};
	int step [4] = '{1, 4, 8, 12};
	mpf_top #(.MS_TICK_CYCLES(10)) mpf_top_inst (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .second_microphone_pin_in(mic_pin),
		.serial_out_or_clock_pin_in(ser_pin),
		.serial_out_or_clock_pin_out(pin_out),
		.serial_out_or_clock_pin_oe(pin_oe), .serial_data_src(sdat),
		.clock_output_function_src(cksrc), .mic_data_out(mic_out),
		.mic_data_valid(mic_vld), .adc_mute(adc_mute), .dac_mute(dac_mute),
		.bank_select(bank), .compression_enable(comp), .bypass_enable(byp),
		.button_volume_active(vol_act), .button_volume_level(level),
		.button_volume_converter_select(conv), .button_gain_increment(gain));
	mpf_button_model mpf_button_model_inst (.pclk(pclk), .mic_pin(mic_pin),
		.ser_pin(ser_pin));
	// ----------------------------------------
	// clock and tasks
	// ----------------------------------------
	always #2.5 pclk = ~pclk;
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// one transfer, held until pready is seen at an edge
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// no wait limit here: only the watchdog ends a stuck transfer
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// press for n cycles, then release and let the sync settle
	task automatic btn(input int p, input int n);
		mpf_button_model_inst.set_pin(p, 1'b1);
		tick(n);
		mpf_button_model_inst.set_pin(p, 1'b0);
		tick(6);
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		tick(8);
		presetn <= 1'b1;
		tick(1);
		for (int i = 0; i < 4; i++)
		begin
			apb(1'b0, radr[i], 32'h0000_0000);
			chk(rd, 32'(rexp[i]));
		end
		// refused accesses raise the slave error
		apb(1'b0, 12'h104, 32'h0000_0000);
		chk(32'(er), 32'h0000_0001);
		apb(1'b1, 12'h108, 32'h0000_00ff);
		chk(32'(er), 32'h0000_0001);
		apb(1'b1, 12'h0f4, 32'h0000_00e7);
		apb(1'b0, 12'h0f4, 32'h0000_0000);
		chk(rd, 32'h0000_00e7);
		// every mute, compression, bypass and reserved code on both pins
		for (int p = 0; p < 2; p++)
			for (int i = 0; i < 14; i++)
			begin
				apb(1'b1, 12'h0f4 + 12'(4 * p), 32'(mcode[i]));
				mpf_button_model_inst.set_pin(p, 1'b1);
				tick(5);
				chk(32'({byp, comp, dac_mute, adc_mute}), 32'(mexp[i]));
				mpf_button_model_inst.set_pin(p, 1'b0);
				tick(5);
				chk(32'({byp, comp, dac_mute, adc_mute}), 32'h0000_0000);
			end
		apb(1'b1, 12'h0f4, 32'h0000_000b);
		btn(0, 4);
		chk(32'(bank), 32'h0000_0001);
		btn(0, 4);
		chk(32'(bank), 32'h0000_0000);
		// mic data path and the serial pin sources
		apb(1'b1, 12'h0f4, 32'h0000_0000);
		mpf_button_model_inst.set_pin(0, 1'b1);
		tick(4);
		chk(32'({mic_vld, mic_out}), 32'h0000_0003);
		mpf_button_model_inst.set_pin(0, 1'b0);
		apb(1'b1, 12'h0f8, 32'h0000_0000);
		sdat <= 1'b1;
		tick(3);
		chk(32'({pin_oe, pin_out}), 32'h0000_0003);
		apb(1'b1, 12'h0f8, 32'h0000_0012);
		tick(2);
		chk(32'({pin_oe, pin_out}), 32'h0000_0002);
		cksrc <= 1'b1;
		tick(2);
		chk(32'({pin_oe, pin_out}), 32'h0000_0003);
		apb(1'b1, 12'h0f8, 32'h0000_0011);
		tick(2);
		chk(32'(pin_oe), 32'h0000_0000);
		// enabling before the setup write starts at the floor
		apb(1'b1, 12'h100, 32'h0000_0080);
		tick(2);
		chk(32'({vol_act, level}), 32'h0000_0300);
		apb(1'b1, 12'h100, 32'h0000_0087);
		tick(2);
		chk(32'(vol_act), 32'h0000_0000);
		apb(1'b1, 12'h0fc, 32'h0000_0028);
		apb(1'b1, 12'h100, 32'h0000_0000);
		tick(2);
		lvl = 20;
		chk(32'(level), 32'(lvl));
		chk(32'(conv), 32'h0000_0000);
		// one short press on the volume-down pin per gain code
		for (int g = 0; g < 4; g++)
		begin
			apb(1'b1, 12'h100, 32'(g << 6));
			chk(32'(gain), 32'(g));
			btn(1, 20);
			lvl += step[g];
			chk(32'(level), 32'(lvl));
		end
		apb(1'b1, 12'h0f4, 32'h0000_0010);
		btn(0, 20);
		chk(32'(level), 32'h0000_0021);
		// hold 300 ms: one step before the hold ends, ramp after it
		apb(1'b1, 12'h0fc, 32'h0000_0021);
		mpf_button_model_inst.set_pin(1, 1'b1);
		tick(2800);
		chk(32'(level), 32'h0000_002d);
		tick(1500);
		chk(32'(level > 9'h02d), 32'h0000_0001);
		mpf_button_model_inst.set_pin(1, 1'b0);
		// hold code 110 never ramps; re-enable reloads the start level
		apb(1'b1, 12'h0fc, 32'h0000_0026);
		apb(1'b1, 12'h100, 32'h0000_00c7);
		apb(1'b1, 12'h100, 32'h0000_00c0);
		tick(2);
		chk(32'(level), 32'h0000_0010);
		btn(1, 4300);
		chk(32'(level), 32'h0000_001c);
		// status: setup written, active, bank back to zero, level
		apb(1'b0, 12'h108, 32'h0000_0000);
		chk(rd, 32'h0000_0a1c);
		chk(32'(er), 32'h0000_0000);
		print_verdict();
	end
	// the tests need about 9.3k cycles; cut a hang well beyond that
	initial
	begin
		#300us;
		mismatches++;
		print_verdict();
	end
endmodule
